// ===== verilog/dpram_port_host.sv
/*
 * Host controller for one port of an asynchronous dual-port SRAM.
 * Takes word, byte and semaphore requests, sequences the pins and
 * returns read data. Assumes the pins are sampled synchronously and
 * that the far port is not addressing the same word.
 */
// How it works
// - Upper-byte write: selects upper lane only, drives lines 8-15, lower lane floats.
// - Lower-byte write: selects lower lane only, drives lines 0-7, upper lane floats.
// - Plain access holds only for distinct addresses; caller keeps ports apart.
// - Semaphore write: line 0 captured at read/write rising edge.
`timescale 1ns/1ps
`default_nettype none
module dpram_port_host
#(
    parameter int unsigned ADDR_WIDTH = dpram_host_pkg::ADDR_WIDTH,
    parameter int unsigned DATA_WIDTH = dpram_host_pkg::DATA_WIDTH
)
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  req_valid_i,
    input  wire logic                  req_write_i,
    input  wire logic                  req_sem_i,
    input  wire logic [1:0]            req_lanes_i,
    input  wire logic [ADDR_WIDTH-1:0] req_addr_i,
    input  wire logic [DATA_WIDTH-1:0] req_wdata_i,
    output logic                       req_ready_o,
    output logic                       rsp_valid_o,
    output logic [DATA_WIDTH-1:0]      rsp_rdata_o,
    output logic                       chip_select_n_o,
    output logic                       read_write_o,
    output logic                       output_enable_n_o,
    output logic                       upper_byte_select_n_o,
    output logic                       lower_byte_select_n_o,
    output logic                       semaphore_select_n_o,
    output logic [ADDR_WIDTH-1:0]      address_o,
    input  wire logic [DATA_WIDTH-1:0] data_lines_i,
    output logic [DATA_WIDTH-1:0]      data_lines_o,
    output logic [1:0]                 data_lines_oe_n_o
);
    localparam int unsigned BW = dpram_host_pkg::BYTE_WIDTH;

    // Refuse widths and counts the sequencer cannot serve
    if (DATA_WIDTH != 2 * BW || ADDR_WIDTH < dpram_host_pkg::SEM_SEL_WIDTH
        || dpram_host_pkg::STROBE_CYC > 2 ** dpram_host_pkg::CNT_WIDTH)
    begin : g_width_check
        $error("dpram_port_host: unsupported widths");
    end

    typedef enum logic [3:0] {
        IDLE    = 4'h1,
        SETUP   = 4'h2,
        STROBE  = 4'h4,
        RECOVER = 4'h8
    } state_t;

    // ******************************
    // Request latch and sequencing
    // ******************************
    state_t                              state;
    logic [dpram_host_pkg::CNT_WIDTH-1:0] count;
    logic                                is_write;
    logic                                is_sem;
    logic [1:0]                          lanes;
    logic                                dec_cs_n;
    logic                                dec_ub_n;
    logic                                dec_lb_n;
    logic                                dec_sem_n;
    logic                                dec_rw;

    function automatic logic [dpram_host_pkg::CNT_WIDTH-1:0] cyc(input int unsigned n);
        cyc = dpram_host_pkg::CNT_WIDTH'(n - 1);
    endfunction

    dpram_lane_decode u_decode
    (
        .sem_i                 (is_sem),
        .write_i               (is_write),
        .lanes_i               (lanes),
        .chip_select_n_o       (dec_cs_n),
        .upper_byte_select_n_o (dec_ub_n),
        .lower_byte_select_n_o (dec_lb_n),
        .semaphore_select_n_o  (dec_sem_n),
        .read_write_o          (dec_rw)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state    <= IDLE;
            count    <= '0;
            is_write <= 1'b0;
            is_sem   <= 1'b0;
            lanes    <= dpram_host_pkg::LANES_NONE;
        end
        else
        begin
            case (state)
                IDLE:
                begin
                    // Empty lane mask on a memory access is dropped
                    if (req_valid_i && (req_sem_i || req_lanes_i != dpram_host_pkg::LANES_NONE))
                    begin
                        state    <= SETUP;
                        count    <= cyc(dpram_host_pkg::SETUP_CYC);
                        is_write <= req_write_i;
                        is_sem   <= req_sem_i;
                        lanes    <= req_sem_i ? 2'h3 : req_lanes_i;
                    end
                end
                SETUP:
                begin
                    if (count == '0)
                    begin
                        state <= STROBE;
                        count <= cyc(dpram_host_pkg::STROBE_CYC);
                    end
                    else
                        count <= count - 1'b1;
                end
                STROBE:
                begin
                    if (count == '0)
                    begin
                        state <= RECOVER;
                        count <= cyc(dpram_host_pkg::RECOVER_CYC);
                    end
                    else
                        count <= count - 1'b1;
                end
                RECOVER:
                begin
                    if (count == '0)
                        state <= IDLE;
                    else
                        count <= count - 1'b1;
                end
                default:
                    state <= IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            req_ready_o <= 1'b0;
        else
            req_ready_o <= (state == IDLE) && !req_valid_i;
    end

    // ******************************
    // Pin drive
    // ******************************
    logic active;
    assign active = (state == SETUP) || (state == STROBE);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chip_select_n_o       <= 1'b1;
            semaphore_select_n_o  <= 1'b1;
            upper_byte_select_n_o <= 1'b1;
            lower_byte_select_n_o <= 1'b1;
            read_write_o          <= 1'b1;
            output_enable_n_o     <= 1'b1;
            address_o             <= '0;
            data_lines_o          <= '0;
            data_lines_oe_n_o     <= 2'h3;
        end
        else if (state == IDLE && req_valid_i)
        begin
            address_o    <= req_addr_i;
            data_lines_o <= req_sem_i ? DATA_WIDTH'(req_wdata_i[dpram_host_pkg::SEM_DATA_BIT])
                                      : req_wdata_i;
        end
        else if (active)
        begin
            chip_select_n_o       <= dec_cs_n;
            semaphore_select_n_o  <= dec_sem_n;
            upper_byte_select_n_o <= dec_ub_n;
            lower_byte_select_n_o <= dec_lb_n;
            // Write strobe low only during STROBE; rises into RECOVER
            read_write_o      <= dec_rw | (state == SETUP && count != '0 ? 1'b1 : 1'b0)
                                 | (state == STROBE && count == '0);
            output_enable_n_o <= is_write || (state == STROBE && count == '0);
            data_lines_oe_n_o <= is_write ? ~lanes : 2'h3;
        end
        else
        begin
            chip_select_n_o       <= 1'b1;
            semaphore_select_n_o  <= 1'b1;
            upper_byte_select_n_o <= 1'b1;
            lower_byte_select_n_o <= 1'b1;
            read_write_o          <= 1'b1;
            output_enable_n_o     <= 1'b1;
            data_lines_oe_n_o     <= 2'h3;
        end
    end

    // ******************************
    // Read capture
    // ******************************
    logic capture;
    assign capture = (state == STROBE) && (count == '0) && !is_write;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
        end
        else
        begin
            rsp_valid_o <= capture;
            if (capture)
            begin
                rsp_rdata_o[DATA_WIDTH-1:BW] <= lanes[1] ? data_lines_i[DATA_WIDTH-1:BW]
                                                         : {BW{1'b0}};
                rsp_rdata_o[BW-1:0]          <= lanes[0] ? data_lines_i[BW-1:0]
                                                         : {BW{1'b0}};
            end
        end
    end

    // ******************************
    // Assertions
    // ******************************
    a_sem_forbidden: assert property (@(posedge clk_i) disable iff (rst_i)
        !semaphore_select_n_o |-> chip_select_n_o && upper_byte_select_n_o
                                   && lower_byte_select_n_o)
        else $error("semaphore select with chip and byte select low");
    a_upper_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (!read_write_o && !upper_byte_select_n_o && lower_byte_select_n_o)
        |-> data_lines_oe_n_o == 2'h1)
        else $error("upper write drives wrong lanes");
    a_lower_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (!read_write_o && upper_byte_select_n_o && !lower_byte_select_n_o)
        |-> data_lines_oe_n_o == 2'h2)
        else $error("lower write drives wrong lanes");
    a_read_floats: assert property (@(posedge clk_i) disable iff (rst_i)
        !output_enable_n_o |-> data_lines_oe_n_o == 2'h3 && read_write_o)
        else $error("host drives lines during read");
    a_read_returns: assert property (@(posedge clk_i) disable iff (rst_i)
        capture |=> rsp_valid_o ##1 !rsp_valid_o)
        else $error("read response not one pulse");
    a_sem_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(semaphore_select_n_o) |-> $stable(address_o))
        else $error("semaphore address moves under select");
    a_sem_wdata: assert property (@(posedge clk_i) disable iff (rst_i)
        (!semaphore_select_n_o && data_lines_oe_n_o == 2'h0)
        |-> data_lines_o[DATA_WIDTH-1:1] == '0)
        else $error("semaphore write data not on line 0");
    a_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == IDLE) ##1 (state == IDLE) |-> chip_select_n_o && semaphore_select_n_o
                                               && data_lines_oe_n_o == 2'h3)
        else $error("pins active while idle");
    a_strobe_len: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(state == STROBE) |-> (state == STROBE) [*4] ##1 (state == RECOVER))
        else $error("strobe length wrong");

    c_mem_write: cover property (@(posedge clk_i) disable iff (rst_i)
        !read_write_o && !chip_select_n_o);
    c_mem_read: cover property (@(posedge clk_i) disable iff (rst_i)
        capture && !is_sem);
    c_sem_write: cover property (@(posedge clk_i) disable iff (rst_i)
        !read_write_o && !semaphore_select_n_o);
    c_sem_read: cover property (@(posedge clk_i) disable iff (rst_i)
        capture && is_sem);
endmodule
`default_nettype wire

// ===== verilog/dpram_host_pkg.sv
/*
 * Constants for the host-side port controller of an asynchronous
 * dual-port static RAM: pin widths, semaphore layout, strobe timing.
 * Assumes a 200 MHz system clock.
 */
package dpram_host_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned ADDR_WIDTH      = 12;
    localparam int unsigned DATA_WIDTH      = 16;
    localparam int unsigned BYTE_WIDTH      = 8;
    localparam int unsigned SEM_COUNT       = 8;
    localparam int unsigned SEM_SEL_WIDTH   = 3;
    localparam int unsigned SEM_DATA_BIT    = 0;
    // Setup, strobe and recovery times of one access
    localparam int unsigned SETUP_NS        = 10;
    localparam int unsigned STROBE_NS       = 20;
    localparam int unsigned RECOVER_NS      = 10;
    localparam int unsigned SETUP_CYC   = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_CYC  = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_WIDTH       = 4;
    localparam logic [1:0]  LANES_NONE      = 2'h0;
endpackage

// ===== verilog/dpram_lane_decode.sv
/*
 * Combinational decode of one request into the active-low byte selects,
 * read/write and semaphore select levels of the memory port.
 * Assumes lane mask bit 1 is the upper byte, bit 0 the lower byte.
 */
`timescale 1ns/1ps
`default_nettype none
module dpram_lane_decode
(
    input  wire logic       sem_i,
    input  wire logic       write_i,
    input  wire logic [1:0] lanes_i,
    output logic            chip_select_n_o,
    output logic            upper_byte_select_n_o,
    output logic            lower_byte_select_n_o,
    output logic            semaphore_select_n_o,
    output logic            read_write_o
);
    always_comb
    begin
        read_write_o = ~write_i;
        if (sem_i)
        begin
            // Semaphore: chip and both bytes deselected
            chip_select_n_o       = 1'b1;
            upper_byte_select_n_o = 1'b1;
            lower_byte_select_n_o = 1'b1;
            semaphore_select_n_o  = 1'b0;
        end
        else
        begin
            chip_select_n_o       = 1'b0;
            upper_byte_select_n_o = ~lanes_i[1];
            lower_byte_select_n_o = ~lanes_i[0];
            semaphore_select_n_o  = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/dpram_port_model.sv
/*
 * Behavioural model of one port of the dual-port RAM: 4K words in two
 * byte lanes and eight one-bit flags. Assumes pins move just after clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module dpram_port_model
(
    input  wire logic        clk_i,
    input  wire logic        cs_n_i,
    input  wire logic        rw_i,
    input  wire logic        oe_n_i,
    input  wire logic        upper_n_i,
    input  wire logic        lower_n_i,
    input  wire logic        flag_sel_n_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [15:0] data_i,
    output logic      [15:0] data_o,
    output logic      [1:0]  drive_o
);
    logic [15:0] mem [0:4096-1];
    logic [7:0]  flags = 8'h00;
    logic        flag_acc, word_acc, last_rw = 1'b1, last_flag, last_word, last_up, last_lo;
    logic [11:0] last_addr;
    logic [15:0] last_data;

    initial
        for (int i = 0; i < 4096; i++)
            mem[i] = 16'h0000;
    // Flag access needs chip or both lanes deselected
    assign flag_acc = !flag_sel_n_i && (cs_n_i || (upper_n_i && lower_n_i));
    assign word_acc = !cs_n_i && flag_sel_n_i;
    // Single port here, so no same-address clash arises
    always_comb
    begin
        drive_o = 2'h0;
        data_o = mem[addr_i];
        if (!oe_n_i && rw_i && flag_acc)
        begin
            drive_o = 2'h3;
            data_o = {16{flags[addr_i[2:0]]}};
        end
        else if (!oe_n_i && rw_i && word_acc)
            drive_o = {!upper_n_i, !lower_n_i};
    end
    // Commit on read/write rising, with pins seen before it
    always @(posedge clk_i)
    begin
        if (!last_rw && rw_i && last_flag)
            flags[last_addr[2:0]] <= last_data[0];
        if (!last_rw && rw_i && last_word && !last_up)
            mem[last_addr][15:8] <= last_data[15:8];
        if (!last_rw && rw_i && last_word && !last_lo)
            mem[last_addr][7:0] <= last_data[7:0];
        last_rw <= rw_i;
        last_flag <= flag_acc;
        last_word <= word_acc;
        last_up <= upper_n_i;
        last_lo <= lower_n_i;
        last_addr <= addr_i;
        last_data <= data_i;
    end
endmodule
`default_nettype wire

// ===== testbench/tb_dual_port_ram_port_access.sv
/*
 * Random and corner-case bench for the port host controller against
 * the port model. Assumes the default 12-bit address, 16-bit data.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_dual_port_ram_port_access;
    logic        clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0;
    logic        req_sem_i = 1'b0, req_ready_o, rsp_valid_o, chip_select_n_o, read_write_o;
    logic        output_enable_n_o, upper_byte_select_n_o, lower_byte_select_n_o;
    logic        semaphore_select_n_o;
    logic [1:0]  req_lanes_i = 2'h0, data_lines_oe_n_o, drive;
    logic [11:0] req_addr_i = 12'h000, address_o;
    logic [15:0] req_wdata_i = 16'h0000, rsp_rdata_o, data_lines_o, dev_data, bus;
    logic [15:0] noise = 16'h5A5A;
    logic [15:0] shadow [0:4096-1];
    logic [7:0]  flag_shadow = 8'h00;
    int          err_count = 0, n_compared = 0, cycles = 0;

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i)
        noise <= ~noise;
    // Undriven lanes show a toggling pattern
    assign bus[15:8] = !data_lines_oe_n_o[1] ? data_lines_o[15:8] :
                       drive[1] ? dev_data[15:8] : noise[15:8];
    assign bus[7:0] = !data_lines_oe_n_o[0] ? data_lines_o[7:0] :
                      drive[0] ? dev_data[7:0] : noise[7:0];

    dpram_port_host dut_u (.clk_i, .rst_i, .req_valid_i, .req_write_i, .req_sem_i, .req_lanes_i,
        .req_addr_i, .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .chip_select_n_o,
        .read_write_o, .output_enable_n_o, .upper_byte_select_n_o, .lower_byte_select_n_o,
        .semaphore_select_n_o, .address_o, .data_lines_i(bus), .data_lines_o,
        .data_lines_oe_n_o);
    dpram_port_model model_u (.clk_i, .cs_n_i(chip_select_n_o), .rw_i(read_write_o),
        .oe_n_i(output_enable_n_o), .upper_n_i(upper_byte_select_n_o),
        .lower_n_i(lower_byte_select_n_o), .flag_sel_n_i(semaphore_select_n_o),
        .addr_i(address_o), .data_i(bus), .data_o(dev_data), .drive_o(drive));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] n, logic [1:0] ln);
        return {ln[1] ? n[15:8] : o[15:8], ln[0] ? n[7:0] : o[7:0]};
    endfunction

    // One request, offered for one cycle once ready is seen, then a bounded wait for read data
    task automatic op(input logic w, input logic s, input logic [1:0] ln,
                      input logic [11:0] a, input logic [15:0] d);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 40)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check({15'h0, req_ready_o}, 16'h0001);
        {req_write_i, req_sem_i, req_lanes_i, req_addr_i, req_wdata_i} = {w, s, ln, a, d};
        req_valid_i = 1'b1;
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b0;
        n = 0;
        while (!w && (s || ln != 2'h0) && rsp_valid_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (!w && (s || ln != 2'h0))
            check(16'(n), 16'(dpram_host_pkg::SETUP_CYC + dpram_host_pkg::STROBE_CYC));
        if (w && s)
            flag_shadow[a[2:0]] = d[0];
        else if (w)
            shadow[a] = merge(shadow[a], d, ln);
        else if (s)
            check(rsp_rdata_o, {16{flag_shadow[a[2:0]]}});
        else if (ln != 2'h0)
            check(rsp_rdata_o, merge(16'h0000, shadow[a], ln));
    endtask

    // Pin watch every cycle
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            err_count++;
            stop_test();
        end
        if (!rst_i)
        begin
            check({15'h0, !semaphore_select_n_o && !chip_select_n_o &&
                   !(upper_byte_select_n_o && lower_byte_select_n_o)}, 16'h0000);
            check({14'h0, ~data_lines_oe_n_o & drive}, 16'h0000);
            if (!chip_select_n_o && !read_write_o && semaphore_select_n_o)
                check({14'h0, data_lines_oe_n_o},
                      {14'h0, upper_byte_select_n_o, lower_byte_select_n_o});
        end
    end

    initial
    begin
        for (int i = 0; i < 4096; i++)
            shadow[i] = 16'h0000;
        void'($urandom(98));
        repeat (4) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        check({8'h00, chip_select_n_o, read_write_o, output_enable_n_o, upper_byte_select_n_o,
               lower_byte_select_n_o, semaphore_select_n_o, data_lines_oe_n_o}, 16'h00FF);
        for (int i = 0; i < 8; i++)
            op(1'b1, 1'b1, 2'h0, {9'($urandom), 3'(i)}, 16'($urandom));
        for (int i = 0; i < 8; i++)
            op(1'b0, 1'b1, 2'h0, {9'($urandom), 3'(i)}, 16'h0000);
        op(1'b1, 1'b0, 2'h3, 12'hFFF, 16'hA55A);
        op(1'b1, 1'b0, 2'h2, 12'hFFF, 16'h3CC3);
        op(1'b1, 1'b0, 2'h0, 12'hFFF, 16'hFFFF);
        op(1'b0, 1'b0, 2'h1, 12'hFFF, 16'h0000);
        op(1'b0, 1'b0, 2'h3, 12'hFFF, 16'h0000);
        op(1'b1, 1'b0, 2'h1, 12'h000, 16'hC3C3);
        op(1'b0, 1'b0, 2'h3, 12'h000, 16'h0000);
        repeat (300)
            op(1'($urandom), $urandom_range(0, 9) < 2, 2'($urandom_range(1, 3)),
               {4'($urandom), 4'h0, 4'($urandom)}, 16'($urandom));
        stop_test();
    end
endmodule
`default_nettype wire
